// ===== core/fsw_pkg.sv
package fsw_pkg;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b000,
        ST_CMD = 3'b001,
        ST_RD = 3'b010,
        ST_WR = 3'b011,
        ST_SKIP = 3'b100
    } fsw_state_t;

    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WREN_VOL = 8'h50;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_RDSR1 = 8'h05;
    localparam logic [7:0] OP_RDSR2 = 8'h35;
    localparam logic [7:0] OP_RDSR3 = 8'h15;
    localparam logic [7:0] OP_WRSR1 = 8'h01;
    localparam logic [7:0] OP_WRSR2 = 8'h31;
    localparam logic [7:0] OP_WRSR3 = 8'h11;
    localparam logic [7:0] OP_RD_UAB = 8'hC8;
    localparam logic [7:0] OP_WR_UAB = 8'hC5;
    localparam logic [7:0] OP_4B_ON = 8'hB7;
    localparam logic [7:0] OP_4B_OFF = 8'hE9;
    localparam logic [7:0] OP_PP = 8'h02;
    localparam logic [7:0] OP_QPP = 8'h32;
    localparam logic [7:0] OP_SE = 8'h20;
    localparam logic [7:0] OP_BE32 = 8'h52;
    localparam logic [7:0] OP_BE64 = 8'hD8;
    localparam logic [7:0] OP_CE = 8'hC7;
    localparam logic [7:0] OP_CE_ALT = 8'h60;
    localparam logic [7:0] OP_SEC_ER = 8'h44;
    localparam logic [7:0] OP_SEC_PG = 8'h42;

    // Writable bit masks per status register
    localparam logic [7:0] SR1_WR_MSK = 8'hFC;
    localparam logic [7:0] SR2_WR_MSK = 8'h7B;
    localparam logic [7:0] SR3_WR_MSK = 8'hE6;
    localparam logic [7:0] LOCK_MSK = 8'h38;
    localparam logic [7:0] PROT1_MSK = 8'h01;
    localparam logic [7:0] QUAD_EN_MSK = 8'h02;
    localparam int ADDR_MODE_BIT = 1;
    localparam logic [7:0] SR_RST = 8'h00;
    localparam logic [7:0] UAB_RST = 8'h00;

    localparam logic [4:0] CNT_BYTE = 5'h08;
    localparam logic [4:0] CNT_FULL = 5'h10;

    localparam int CLK_NS = 50;
    localparam int T_W_NS = 10000;
    localparam logic [7:0] T_W_CYC = 8'((T_W_NS + CLK_NS - 1) / CLK_NS);

endpackage

// ===== core/fsw_ctrl.sv
`timescale 1ns/100ps
module fsw_ctrl
(
    // Clock, resets, enable
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic por_rst,
    input wire logic clk_en,
    // Serial link pins
    input wire logic cs_n_pin,
    input wire logic sclk_pin,
    input wire logic [3:0] io_pin_in,
    output logic [3:0] io_out_r,
    output logic [3:0] io_oe_r,
    // Neighbouring logic, same clock
    input wire logic quad_command_mode,
    input wire logic array_done,
    input wire logic addr_top_load,
    input wire logic [7:0] addr_top_in,
    // State seen by the rest of the device
    output logic write_enable_latch_r,
    output logic busy_r,
    output logic address_mode_status_r,
    output logic [7:0] status1_r,
    output logic [7:0] status2_r,
    output logic [7:0] status3_r,
    output logic [7:0] upper_address_byte_r,
    output logic [7:0] addr_top_r,
    output logic array_go_r,
    output logic [7:0] array_op_r
);

    function automatic logic [7:0] fsw_merge(input logic [7:0] old, input logic [7:0] d,
                                             input logic [7:0] msk, input logic [7:0] keep);
        fsw_merge = (old & ~msk) | (d & msk) | (old & keep);
    endfunction

    function automatic fsw_pkg::fsw_state_t fsw_decode(input logic [7:0] op);
        case (op)
            fsw_pkg::OP_RDSR1, fsw_pkg::OP_RDSR2, fsw_pkg::OP_RDSR3, fsw_pkg::OP_RD_UAB:
                fsw_decode = fsw_pkg::ST_RD;
            fsw_pkg::OP_WRSR1, fsw_pkg::OP_WRSR2, fsw_pkg::OP_WRSR3, fsw_pkg::OP_WR_UAB:
                fsw_decode = fsw_pkg::ST_WR;
            default:
                fsw_decode = fsw_pkg::ST_SKIP;
        endcase
    endfunction

    function automatic logic fsw_needs_latch(input logic [7:0] op);
        case (op)
            fsw_pkg::OP_PP, fsw_pkg::OP_QPP, fsw_pkg::OP_SE, fsw_pkg::OP_BE32, fsw_pkg::OP_BE64,
            fsw_pkg::OP_CE, fsw_pkg::OP_CE_ALT, fsw_pkg::OP_SEC_ER, fsw_pkg::OP_SEC_PG:
                fsw_needs_latch = 1'b1;
            default:
                fsw_needs_latch = 1'b0;
        endcase
    endfunction

    logic rst;
    logic cs_s1, cs_s2, cs_s3;
    logic sck_s1, sck_s2, sck_s3;
    logic [3:0] io_s1, io_s2;
    logic sck_rise, sck_fall, cs_end, quad;
    fsw_pkg::fsw_state_t st_r;
    logic [4:0] cnt_r, cnt_nxt, step;
    logic [7:0] sh_r, sh_nxt, op_r, d0_r, d1_r;
    logic vol_arm_r;
    logic [7:0] nv1_r, nv2_r, nv3_r;
    logic [7:0] bcnt_r;
    logic [2:0] txc_r;
    logic [7:0] tx_r, tx_byte, live;
    logic fr_simple, fr_wr, is_sr, two_byte, wr_done;
    logic ev_wren, ev_wrdi, ev_vol, ev_srn, ev_srv, ev_uab, ev_arr;
    logic [7:0] sr1_new, sr2_new, sr3_new, sr2_msk, sr2_keep;

    assign rst = sys_rst | por_rst;
    assign quad = quad_command_mode;

    // Pins cross into clk_sys; data is taken from the second stage, edges from the second and third
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            cs_s3 <= 1'b1;
            sck_s1 <= 1'b0;
            sck_s2 <= 1'b0;
            sck_s3 <= 1'b0;
            io_s1 <= 4'h0;
            io_s2 <= 4'h0;
        end
        else if (clk_en)
        begin
            cs_s1 <= cs_n_pin;
            cs_s2 <= cs_s1;
            cs_s3 <= cs_s2;
            sck_s1 <= sclk_pin;
            sck_s2 <= sck_s1;
            sck_s3 <= sck_s2;
            io_s1 <= io_pin_in;
            io_s2 <= io_s1;
        end
    end

    assign sck_rise = sck_s2 & ~sck_s3 & ~cs_s2;
    assign sck_fall = ~sck_s2 & sck_s3 & ~cs_s2;
    assign cs_end = cs_s2 & ~cs_s3;
    assign step = quad ? 5'h04 : 5'h01;
    assign cnt_nxt = cnt_r + step;
    assign sh_nxt = quad ? {sh_r[3:0], io_s2} : {sh_r[6:0], io_s2[0]};

    // Command and data shifter, sampled on link rising edges
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            st_r <= fsw_pkg::ST_IDLE;
            cnt_r <= 5'h00;
            sh_r <= 8'h00;
            op_r <= 8'h00;
            d0_r <= 8'h00;
            d1_r <= 8'h00;
        end
        else if (clk_en)
        begin
            if (cs_s2)
            begin
                st_r <= fsw_pkg::ST_IDLE;
            end
            else if (st_r == fsw_pkg::ST_IDLE)
            begin
                st_r <= fsw_pkg::ST_CMD;
                cnt_r <= 5'h00;
            end
            else if (sck_rise && st_r == fsw_pkg::ST_CMD)
            begin
                sh_r <= sh_nxt;
                cnt_r <= cnt_nxt;
                if (cnt_nxt == fsw_pkg::CNT_BYTE)
                begin
                    op_r <= sh_nxt;
                    cnt_r <= 5'h00;
                    st_r <= fsw_decode(sh_nxt);
                end
            end
            else if (sck_rise && st_r == fsw_pkg::ST_WR && cnt_r != fsw_pkg::CNT_FULL)
            begin
                sh_r <= sh_nxt;
                cnt_r <= cnt_nxt;
                if (cnt_nxt == fsw_pkg::CNT_BYTE)
                begin
                    d0_r <= sh_nxt;
                end
                if (cnt_nxt == fsw_pkg::CNT_FULL)
                begin
                    d1_r <= sh_nxt;
                end
            end
        end
    end

    // Frame-end events; every write acts only when chip select rises
    assign fr_simple = cs_end && st_r == fsw_pkg::ST_SKIP;
    assign fr_wr = cs_end && st_r == fsw_pkg::ST_WR && cnt_r >= fsw_pkg::CNT_BYTE && !busy_r;
    assign is_sr = op_r == fsw_pkg::OP_WRSR1 || op_r == fsw_pkg::OP_WRSR2 || op_r == fsw_pkg::OP_WRSR3;
    assign two_byte = op_r == fsw_pkg::OP_WRSR1 && cnt_r == fsw_pkg::CNT_FULL;
    assign ev_wren = fr_simple && op_r == fsw_pkg::OP_WREN && !busy_r;
    assign ev_wrdi = fr_simple && op_r == fsw_pkg::OP_WRDI;
    assign ev_vol = fr_simple && op_r == fsw_pkg::OP_WREN_VOL && !busy_r;
    assign ev_srv = fr_wr && is_sr && vol_arm_r;
    assign ev_srn = fr_wr && is_sr && !vol_arm_r && write_enable_latch_r;
    assign ev_uab = fr_wr && op_r == fsw_pkg::OP_WR_UAB && write_enable_latch_r;
    assign ev_arr = fr_simple && fsw_needs_latch(op_r) && write_enable_latch_r && !busy_r;
    assign wr_done = busy_r && bcnt_r == 8'h01;

    // Volatile arm lasts exactly until the next frame ends
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            vol_arm_r <= 1'b0;
        end
        else if (clk_en)
        begin
            if (ev_vol)
            begin
                vol_arm_r <= 1'b1;
            end
            else if (cs_end)
            begin
                vol_arm_r <= 1'b0;
            end
        end
    end

    // Set wins over a clear arriving in the same cycle
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            write_enable_latch_r <= 1'b0;
        end
        else if (clk_en)
        begin
            if (ev_wren)
            begin
                write_enable_latch_r <= 1'b1;
            end
            else if (ev_wrdi || wr_done || array_done)
            begin
                write_enable_latch_r <= 1'b0;
            end
        end
    end

    // Self-timed non-volatile write cycle
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            busy_r <= 1'b0;
            bcnt_r <= 8'h00;
        end
        else if (clk_en)
        begin
            if (ev_srn)
            begin
                busy_r <= 1'b1;
                bcnt_r <= fsw_pkg::T_W_CYC;
            end
            else if (busy_r)
            begin
                bcnt_r <= bcnt_r - 8'h01;
                busy_r <= !wr_done;
            end
        end
    end

    assign sr2_msk = quad ? (fsw_pkg::SR2_WR_MSK & ~fsw_pkg::QUAD_EN_MSK) : fsw_pkg::SR2_WR_MSK;
    assign sr2_keep = fsw_pkg::LOCK_MSK | (vol_arm_r ? fsw_pkg::PROT1_MSK : 8'h00);
    assign sr1_new = fsw_merge(status1_r, d0_r, fsw_pkg::SR1_WR_MSK, 8'h00);
    assign sr2_new = fsw_merge(status2_r, two_byte ? d1_r : d0_r, sr2_msk, sr2_keep);
    assign sr3_new = fsw_merge(status3_r, d0_r, fsw_pkg::SR3_WR_MSK, 8'h00);

    // Stored copy survives sys_rst; only power-up wipes it
    always_ff @(posedge clk_sys)
    begin
        if (por_rst)
        begin
            nv1_r <= fsw_pkg::SR_RST;
            nv2_r <= fsw_pkg::SR_RST;
            nv3_r <= fsw_pkg::SR_RST;
        end
        else if (clk_en && ev_srn)
        begin
            nv1_r <= (op_r == fsw_pkg::OP_WRSR1) ? sr1_new : nv1_r;
            nv2_r <= (op_r == fsw_pkg::OP_WRSR2 || two_byte) ? sr2_new : nv2_r;
            nv3_r <= (op_r == fsw_pkg::OP_WRSR3) ? sr3_new : nv3_r;
        end
    end

    // Active status values; volatile writes touch only these
    always_ff @(posedge clk_sys)
    begin
        if (por_rst)
        begin
            status1_r <= fsw_pkg::SR_RST;
            status2_r <= fsw_pkg::SR_RST;
            status3_r <= fsw_pkg::SR_RST;
        end
        else if (sys_rst)
        begin
            status1_r <= nv1_r;
            status2_r <= nv2_r;
            status3_r <= nv3_r;
        end
        else if (clk_en && (ev_srn || ev_srv))
        begin
            status1_r <= (op_r == fsw_pkg::OP_WRSR1) ? sr1_new : status1_r;
            status2_r <= (op_r == fsw_pkg::OP_WRSR2 || two_byte) ? sr2_new : status2_r;
            status3_r <= (op_r == fsw_pkg::OP_WRSR3) ? sr3_new : status3_r;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (por_rst)
        begin
            address_mode_status_r <= fsw_pkg::SR_RST[fsw_pkg::ADDR_MODE_BIT];
        end
        else if (sys_rst)
        begin
            address_mode_status_r <= nv3_r[fsw_pkg::ADDR_MODE_BIT];
        end
        else if (clk_en && fr_simple)
        begin
            if (op_r == fsw_pkg::OP_4B_ON)
            begin
                address_mode_status_r <= 1'b1;
            end
            else if (op_r == fsw_pkg::OP_4B_OFF)
            begin
                address_mode_status_r <= 1'b0;
            end
        end
    end

    // Upper address byte and the top byte offered to the array
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            upper_address_byte_r <= fsw_pkg::UAB_RST;
            addr_top_r <= fsw_pkg::UAB_RST;
        end
        else if (clk_en)
        begin
            if (ev_uab)
            begin
                upper_address_byte_r <= d0_r;
            end
            else if (address_mode_status_r && addr_top_load)
            begin
                upper_address_byte_r <= addr_top_in;
            end
            addr_top_r <= address_mode_status_r ? addr_top_in : upper_address_byte_r;
        end
    end

    // Launch for array operations; the array engine reports back on array_done
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            array_go_r <= 1'b0;
            array_op_r <= 8'h00;
        end
        else if (clk_en)
        begin
            array_go_r <= ev_arr;
            if (ev_arr)
            begin
                array_op_r <= op_r;
            end
        end
    end

    // Live view reloaded every byte so a polled busy bit is current
    always_comb
    begin
        case (op_r)
            fsw_pkg::OP_RDSR1: live = {status1_r[7:2], write_enable_latch_r, busy_r};
            fsw_pkg::OP_RDSR2: live = status2_r;
            fsw_pkg::OP_RDSR3: live = {status3_r[7:1], address_mode_status_r};
            default: live = upper_address_byte_r;
        endcase
    end

    assign tx_byte = (txc_r == 3'h0) ? live : tx_r;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            io_out_r <= 4'h0;
            io_oe_r <= 4'h0;
            txc_r <= 3'h0;
            tx_r <= 8'h00;
        end
        else if (clk_en)
        begin
            if (st_r != fsw_pkg::ST_RD)
            begin
                io_oe_r <= 4'h0;
                txc_r <= 3'h0;
            end
            else if (sck_fall)
            begin
                io_oe_r <= quad ? 4'hF : 4'h2;
                io_out_r <= quad ? tx_byte[7:4] : {2'b00, tx_byte[7], 1'b0};
                tx_r <= quad ? {tx_byte[3:0], 4'h0} : {tx_byte[6:0], 1'b0};
                txc_r <= txc_r + (quad ? 3'h4 : 3'h1);
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    wren_sets_a: assert property (clk_en && ev_wren |=> write_enable_latch_r)
        else $error("latch not set by write enable");
    wrdi_clears_a: assert property (clk_en && ev_wrdi && !ev_wren |=> !write_enable_latch_r)
        else $error("latch not cleared by write disable");
    vol_latch_a: assert property (clk_en && ev_srv && !write_enable_latch_r |=> !write_enable_latch_r)
        else $error("volatile write touched latch");
    vol_busy_a: assert property (clk_en && ev_srv |=> !busy_r [*3])
        else $error("busy during volatile write");
    nv_busy_a: assert property (clk_en && ev_srn |=> busy_r && bcnt_r == fsw_pkg::T_W_CYC)
        else $error("write cycle not started");
    busy_end_a: assert property (clk_en && wr_done && !ev_wren |=> !busy_r && !write_enable_latch_r)
        else $error("write cycle end wrong");
    lock_otp_a: assert property (clk_en |=> (status2_r & $past(status2_r) & fsw_pkg::LOCK_MSK)
                                            == ($past(status2_r) & fsw_pkg::LOCK_MSK))
        else $error("lock bit cleared");
    quad_en_fixed_a: assert property (clk_en && quad && (ev_srn || ev_srv)
                                      |=> status2_r[1] == $past(status2_r[1]))
        else $error("quad enable changed in quad mode");
    uab_load_a: assert property (clk_en && address_mode_status_r && addr_top_load && !ev_uab
                                 |=> upper_address_byte_r == $past(addr_top_in))
        else $error("upper byte not replaced");
    rd_drive_a: assert property (st_r != fsw_pkg::ST_RD && $past(st_r) != fsw_pkg::ST_RD && $past(clk_en)
                                 |-> io_oe_r == 4'h0)
        else $error("output driven outside read");
    arr_gate_a: assert property (clk_en && fr_simple && !write_enable_latch_r |=> !array_go_r)
        else $error("array launched without latch");

    nv_write_c: cover property (clk_en && ev_srn);
    two_byte_c: cover property (clk_en && ev_srn && two_byte);
    vol_write_c: cover property (clk_en && ev_srv);
    busy_read_c: cover property (busy_r && st_r == fsw_pkg::ST_RD && sck_fall);

endmodule // fsw_ctrl

// ===== verification/fsw_host.sv
`timescale 1ns/100ps
module fsw_host
(
    // System clock
    input wire logic clk_sys,
    // Link pins
    output logic cs_n_pin = 1'b1,
    output logic sclk_pin = 1'b0,
    output logic [3:0] io_pin_in = 4'h5,
    input wire logic [3:0] io_out_r,
    input wire logic [3:0] io_oe_r,
    output logic [3:0] rd_oe = 4'h0,
    // Captured answer
    output logic [15:0] rd_val = 16'h0000,
    output logic rd_vld = 1'b0
);
    // One link period is eight system clocks; data changes while the link clock is low
    task automatic link_edge(input logic [3:0] v, input logic [1:0] smp);
        @(posedge clk_sys);
        sclk_pin <= 1'b0;
        io_pin_in <= v;
        repeat (4) @(posedge clk_sys);
        sclk_pin <= 1'b1;
        repeat (3) @(posedge clk_sys);
        // Sampled late in the high phase so the registered answer has surely settled
        if (smp == 2'd2)
            rd_val <= {rd_val[11:0], io_out_r};
        else if (smp == 2'd1)
            rd_val <= {rd_val[14:0], io_out_r[1]};
        if (smp != 2'd0)
            rd_oe <= io_oe_r;
    endtask

    task automatic frame(input logic q, input logic [7:0] cmd, input logic [15:0] dat, input int ndat, input int nrd);
        logic [31:0] sh;
        int w;
        w = q ? 4 : 1;
        sh = {cmd, dat, 8'h00};
        @(posedge clk_sys);
        cs_n_pin <= 1'b0;
        rd_val <= 16'h0000;
        repeat (4) @(posedge clk_sys);
        for (int i = 0; i < 8 + ndat; i += w)
        begin
            link_edge(q ? sh[31:28] : {3'b000, sh[31]}, 2'd0);
            sh = sh << w;
        end
        // A released data line shows no stale value
        for (int i = 0; i < nrd; i++)
            link_edge(~io_pin_in, q ? 2'd2 : 2'd1);
        @(posedge clk_sys);
        cs_n_pin <= 1'b1;
        io_pin_in <= ~io_pin_in;
        @(posedge clk_sys);
        sclk_pin <= 1'b0;
        rd_vld <= (nrd > 0);
        @(posedge clk_sys);
        rd_vld <= 1'b0;
        repeat (6) @(posedge clk_sys);
    endtask
endmodule // fsw_host

// ===== verification/flash_status_write_control_bench.sv
`timescale 1ns/100ps
module flash_status_write_control_bench;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic por_rst = 1'b1;
    logic clk_en = 1'b1;
    logic quad_command_mode = 1'b0;
    logic array_done = 1'b0;
    logic addr_top_load = 1'b0;
    logic [7:0] addr_top_in = 8'h00;
    logic cs_n_pin, sclk_pin, rd_vld, write_enable_latch_r, busy_r, address_mode_status_r, array_go_r;
    logic [3:0] io_pin_in, io_out_r, io_oe_r, rd_oe;
    logic [15:0] rd_val;
    logic [7:0] status1_r, status2_r, status3_r, upper_address_byte_r, addr_top_r, array_op_r;
    logic [15:0] exp_q[$];
    logic [15:0] exp_oe_q[$];
    logic [7:0] a, b, c;
    int n_mismatch = 0;
    int n_tests = 0;
    int n_go = 0;
    int seed = 90115;

    always #25 clk_sys = ~clk_sys;

    fsw_ctrl dut
    (
        .clk_sys, .sys_rst, .por_rst, .clk_en, .cs_n_pin, .sclk_pin, .io_pin_in, .io_out_r, .io_oe_r,
        .quad_command_mode, .array_done, .addr_top_load, .addr_top_in, .write_enable_latch_r, .busy_r,
        .address_mode_status_r, .status1_r, .status2_r, .status3_r, .upper_address_byte_r, .addr_top_r,
        .array_go_r, .array_op_r
    );

    fsw_host host
    (
        .clk_sys, .cs_n_pin, .sclk_pin, .io_pin_in, .io_out_r, .io_oe_r, .rd_oe, .rd_val, .rd_vld
    );

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask

    task automatic end_sim;
        $display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic op(input logic q, input logic [7:0] cmd);
        host.frame(q, cmd, 16'h0000, 0, 0);
    endtask

    task automatic wr(input logic [7:0] cmd, input logic [15:0] dat, input int ndat);
        host.frame(1'b0, cmd, dat, ndat, 0);
    endtask

    task automatic rd(input logic [7:0] cmd, input logic [7:0] v, input int n);
        exp_q.push_back(n == 16 ? {v, v} : {8'h00, v});
        exp_oe_q.push_back(16'h0002);
        host.frame(1'b0, cmd, 16'h0000, 0, n);
    endtask

    // Busy must end within 400 system clocks of the wait, twice the self-timed write span
    task automatic wait_busy;
        int k;
        k = 0;
        while (busy_r !== 1'b0 && k < 400)
        begin
            @(posedge clk_sys);
            k++;
        end
        @(posedge clk_sys);
        chk(16'(busy_r), 16'h0000);
    endtask

    always @(posedge clk_sys)
        if (rd_vld === 1'b1)
        begin
            chk(rd_val, exp_q.pop_front());
            chk(16'(rd_oe), exp_oe_q.pop_front());
        end

    always @(posedge clk_sys)
        if (array_go_r === 1'b1)
            n_go++;

    initial
    begin
        a = 8'($random(seed));
        b = 8'($random(seed)) | 8'h08;
        c = 8'($random(seed));
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        por_rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rd(fsw_pkg::OP_RD_UAB, fsw_pkg::UAB_RST, 16);
        op(1'b0, fsw_pkg::OP_WREN);
        chk(16'(write_enable_latch_r), 16'h0001);
        op(1'b0, fsw_pkg::OP_WRDI);
        chk(16'(write_enable_latch_r), 16'h0000);
        wr(fsw_pkg::OP_WRSR1, {a, b}, 16);
        rd(fsw_pkg::OP_RDSR1, 8'h00, 8);
        op(1'b0, fsw_pkg::OP_WREN);
        wr(fsw_pkg::OP_WRSR1, {a, b}, 16);
        rd(fsw_pkg::OP_RDSR1, (a & fsw_pkg::SR1_WR_MSK) | 8'h03, 8);
        wait_busy();
        chk(16'(write_enable_latch_r), 16'h0000);
        rd(fsw_pkg::OP_RDSR2, b & fsw_pkg::SR2_WR_MSK, 8);
        op(1'b0, fsw_pkg::OP_WREN_VOL);
        wr(fsw_pkg::OP_WRSR2, 16'h0000, 8);
        chk(16'({busy_r, write_enable_latch_r}), 16'h0000);
        rd(fsw_pkg::OP_RDSR2, b & 8'h39, 8);
        op(1'b0, fsw_pkg::OP_WREN);
        wr(fsw_pkg::OP_WRSR1, {c, 8'h00}, 8);
        wait_busy();
        chk(16'(status2_r), 16'(b & 8'h39));
        rd(fsw_pkg::OP_RDSR1, c & fsw_pkg::SR1_WR_MSK, 8);
        quad_command_mode <= 1'b1;
        op(1'b1, fsw_pkg::OP_WREN_VOL);
        host.frame(1'b1, fsw_pkg::OP_WRSR2, {(b & 8'h39) ^ fsw_pkg::QUAD_EN_MSK, 8'h00}, 8, 0);
        exp_q.push_back({b & 8'h39, b & 8'h39});
        exp_oe_q.push_back(16'h000F);
        host.frame(1'b1, fsw_pkg::OP_RDSR2, 16'h0000, 0, 4);
        quad_command_mode <= 1'b0;
        chk(16'(status2_r), 16'(b & 8'h39));
        wr(fsw_pkg::OP_WR_UAB, {c, 8'h00}, 8);
        rd(fsw_pkg::OP_RD_UAB, 8'h00, 8);
        op(1'b0, fsw_pkg::OP_WREN);
        wr(fsw_pkg::OP_WR_UAB, {a, 8'h00}, 8);
        rd(fsw_pkg::OP_RD_UAB, a, 8);
        chk(16'(addr_top_r), 16'(a));
        op(1'b0, fsw_pkg::OP_4B_ON);
        chk(16'(address_mode_status_r), 16'h0001);
        rd(fsw_pkg::OP_RDSR3, 8'h01, 8);
        addr_top_load <= 1'b1;
        addr_top_in <= c;
        @(posedge clk_sys);
        addr_top_load <= 1'b0;
        addr_top_in <= ~c;
        repeat (3) @(posedge clk_sys);
        chk(16'(upper_address_byte_r), 16'(c));
        chk(16'(addr_top_r), {8'h00, ~c});
        op(1'b0, fsw_pkg::OP_4B_OFF);
        rd(fsw_pkg::OP_RD_UAB, c, 8);
        chk(16'({address_mode_status_r, addr_top_r}), 16'(c));
        op(1'b0, fsw_pkg::OP_4B_ON);
        op(1'b0, fsw_pkg::OP_WREN);
        // A frozen block must ignore a completion pulse
        clk_en <= 1'b0;
        array_done <= 1'b1;
        @(posedge clk_sys);
        array_done <= 1'b0;
        repeat (2) @(posedge clk_sys);
        clk_en <= 1'b1;
        repeat (2) @(posedge clk_sys);
        chk(16'(write_enable_latch_r), 16'h0001);
        op(1'b0, fsw_pkg::OP_PP);
        chk(16'(n_go), 16'h0001);
        chk(16'(array_op_r), 16'(fsw_pkg::OP_PP));
        array_done <= 1'b1;
        @(posedge clk_sys);
        array_done <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk(16'(write_enable_latch_r), 16'h0000);
        op(1'b0, fsw_pkg::OP_SE);
        chk({8'(n_go), array_op_r}, {8'h01, fsw_pkg::OP_PP});
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        chk(16'(status2_r), 16'(b & fsw_pkg::SR2_WR_MSK));
        chk({upper_address_byte_r, 7'h00, address_mode_status_r}, 16'h0000);
        end_sim();
    end

    // Whole sequence needs well under fifteen thousand system clocks
    initial
    begin
        repeat (60000) @(posedge clk_sys);
        n_mismatch++;
        end_sim();
    end
endmodule // flash_status_write_control_bench
